// File: src/ttu_match.sv
// one qualifier comparator: range plus per-bit mask on address and data
// assumes qualifier values are stable while the trace is running
`timescale 1ns/10ps
`default_nettype none
module ttu_match (
  input wire ttu_pkg::ttu_cycle_s cyc,
  input wire ttu_pkg::ttu_qual_s qual,
  output logic hit
);
  import ttu_pkg::*;
  wire [ADDR_W-1:0] a_m = cyc.addr & qual.addr_mask;
  wire [DATA_W-1:0] d_m = cyc.data & qual.data_mask;
  wire addr_ok = (a_m >= (qual.addr_lo & qual.addr_mask)) &&
                 (a_m <= (qual.addr_hi & qual.addr_mask));
  wire data_ok = (d_m >= (qual.data_lo & qual.data_mask)) &&
                 (d_m <= (qual.data_hi & qual.data_mask));
  wire is_data = (cyc.kind == BUS_READ) || (cyc.kind == BUS_WRITE);
  wire type_ok = (qual.cyc_type == CYC_ALL) ||
                 ((qual.cyc_type == CYC_DATA) && is_data) ||
                 ((qual.cyc_type == CYC_FETCH) && (cyc.kind == BUS_FETCH));
  wire live = cyc.valid && cyc.executed && (cyc.kind != BUS_FLUSH);
  assign hit = qual.enable && live && type_ok && addr_ok && data_ok;
endmodule : ttu_match
`default_nettype wire

// File: src/ttu_pkg.sv
// package for the trace and trigger unit
// assumes a single 100 MHz system clock
package ttu_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_TRIG = 3;
  localparam int NUM_QUAL = 50;
  localparam int TS_W = 32;
  localparam int SYS_CLK_KHZ = 100000;
  localparam int HK_CLK_KHZ = 25000;
  localparam int HK_DIV = SYS_CLK_KHZ / HK_CLK_KHZ;
  localparam logic [15:0] CPU_CLK_KHZ_RST = 16'h4e20;
  localparam logic [1:0] CYC_ALL = 2'h0;
  localparam logic [1:0] CYC_DATA = 2'h1;
  localparam logic [1:0] CYC_FETCH = 2'h2;
  localparam logic [1:0] CYC_NONE = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  typedef enum logic [1:0] {
    BUS_FETCH = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10,
    BUS_FLUSH = 2'b11
  } ttu_kind_e;

  typedef struct packed {
    logic valid;
    logic executed;
    logic external;
    ttu_kind_e kind;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ttu_cycle_s;

  typedef struct packed {
    logic enable;
    logic [1:0] cyc_type;
    logic [ADDR_W-1:0] addr_lo;
    logic [ADDR_W-1:0] addr_hi;
    logic [ADDR_W-1:0] addr_mask;
    logic [DATA_W-1:0] data_lo;
    logic [DATA_W-1:0] data_hi;
    logic [DATA_W-1:0] data_mask;
  } ttu_qual_s;

  typedef struct packed {
    logic [TS_W-1:0] stamp;
    logic external;
    ttu_kind_e kind;
    logic [1:0] size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ttu_frame_s;
endpackage : ttu_pkg

// File: src/ttu_top.sv
// trace and trigger unit top: three triggers, one filter, trace frames
// assumes cycle records come from logic on SYS_CLK, config from housekeeping
//
// Contract
// - triggers match address and data ranges
// - match drives trace or halts emulation
// - break option halts emulation on trigger
// - zero data mask bits are don't-care
// - address mask excludes address bits
// - only executed cycles trigger or record
// - internal and external buses both observed
// - configuration via 25 MHz housekeeping port
// - manual trace off also freezes shadow
// - three triggers plus one filter unit
// - triggers stop trace, emulation, or filter
// - timestamp scaled by cpu clock setting
// - new qualifiers and cpu clock setting load only on restart
// - cycle type restricts to data cycles
// - frames carry direction and size
// - window mode: trigger1 starts, trigger2 stops
// - up to fifty qualifiers per list
`timescale 1ns/10ps
`default_nettype none
module ttu_top #(
  parameter int NQ = ttu_pkg::NUM_QUAL
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire ttu_pkg::ttu_cycle_s CYCLE_IN,
  input wire logic HK_WE,
  input wire logic [1:0] HK_UNIT,
  input wire logic [5:0] HK_INDEX,
  input wire ttu_pkg::ttu_qual_s HK_QUAL,
  input wire logic TRACE_ON,
  input wire logic BREAK_ON_TRIG,
  input wire logic STOP_TRACE_ON_TRIG,
  input wire logic FILTER_ON,
  input wire logic WINDOW_MODE,
  input wire logic [2:0] TRIG_ARM,
  input wire logic [15:0] CPU_CLK_KHZ,
  output logic EMU_HALT,
  output logic TRACE_REC,
  output logic SHADOW_EN,
  output logic FRAME_VALID,
  output ttu_pkg::ttu_frame_s FRAME,
  output logic [2:0] TRIG_HIT,
  output logic HK_ACK
);
  import ttu_pkg::*;

  // ---------------------------------------------------------------
  // housekeeping tick
  // ---------------------------------------------------------------
  logic [1:0] hk_cnt_r;
  wire hk_tick = (hk_cnt_r == 2'(HK_DIV - 1));
  always_ff @(posedge SYS_CLK) begin
    if (RST) hk_cnt_r <= 2'h0;
    else hk_cnt_r <= hk_tick ? 2'h0 : hk_cnt_r + 2'h1;
  end

  // ---------------------------------------------------------------
  // qualifier storage: staged and live copies
  // ---------------------------------------------------------------
  localparam int NU = NUM_TRIG + 1;
  ttu_qual_s stage_r [NU][NQ];
  ttu_qual_s live_r [NU][NQ];
  logic running_r;
  logic trace_q_r;
  // loads only on a rising switch
  wire start = TRACE_ON && !trace_q_r;
  wire hk_wr = HK_WE && hk_tick && (int'(HK_INDEX) < NQ);
  logic [NU-1:0][NQ-1:0] hit_w;

  genvar u, q;
  generate
    for (u = 0; u < NU; u++) begin : g_unit
      for (q = 0; q < NQ; q++) begin : g_q
        always_ff @(posedge SYS_CLK) begin
          if (RST) begin
            stage_r[u][q] <= '0;
            live_r[u][q] <= '0;
          end else begin
            if (hk_wr && HK_UNIT == 2'(u) && HK_INDEX == 6'(q)) stage_r[u][q] <= HK_QUAL;
            if (start) live_r[u][q] <= stage_r[u][q];
          end
        end
        ttu_match u_match (
          .cyc(CYCLE_IN),
          .qual(live_r[u][q]),
          .hit(hit_w[u][q])
        );
      end
    end
  endgenerate

  wire [NU-1:0] unit_hit;
  generate
    for (u = 0; u < NU; u++) begin : g_or
      assign unit_hit[u] = |hit_w[u];
    end
  endgenerate

  // ---------------------------------------------------------------
  // trigger actions
  // ---------------------------------------------------------------
  wire [2:0] armed_hit = unit_hit[2:0] & TRIG_ARM;
  wire any_trig = |armed_hit;
  logic window_r;
  logic halt_r;
  wire window_nxt = armed_hit[0] ? 1'b1 : (armed_hit[1] ? 1'b0 : window_r);
  wire filt_ok = !FILTER_ON || (WINDOW_MODE ? (window_r || armed_hit[0]) : unit_hit[3]);
  wire live_cyc = CYCLE_IN.valid && CYCLE_IN.executed && (CYCLE_IN.kind != BUS_FLUSH);
  wire rec_go = running_r && live_cyc && filt_ok;
  wire trig_stop = running_r && any_trig && STOP_TRACE_ON_TRIG;
  wire halt_set = running_r && any_trig && BREAK_ON_TRIG;
  wire running_nxt = (!TRACE_ON || trig_stop) ? 1'b0 : (start ? 1'b1 : running_r);
  wire halt_nxt = halt_set ? 1'b1 : (start ? 1'b0 : halt_r);

  // ---------------------------------------------------------------
  // trace switch edge and run state
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) trace_q_r <= 1'b0;
    else trace_q_r <= TRACE_ON;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) running_r <= 1'b0;
    else running_r <= running_nxt;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) window_r <= 1'b0;
    else if (start) window_r <= 1'b0;
    else if (running_r) window_r <= window_nxt;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) halt_r <= 1'b0;
    else halt_r <= halt_nxt;
  end

  // ---------------------------------------------------------------
  // timestamp
  // ---------------------------------------------------------------
  logic [15:0] khz_r;
  logic [31:0] acc_r;
  logic [TS_W-1:0] stamp_r;
  wire [31:0] acc_sum = acc_r + 32'(khz_r);
  wire ns_step = acc_sum >= 32'(SYS_CLK_KHZ);
  wire [31:0] acc_nxt = ns_step ? acc_sum - 32'(SYS_CLK_KHZ) : acc_sum;
  always_ff @(posedge SYS_CLK) begin
    if (RST) khz_r <= CPU_CLK_KHZ_RST;
    else if (start) khz_r <= CPU_CLK_KHZ;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      acc_r <= 32'h0;
      stamp_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      if (ns_step) stamp_r <= stamp_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      FRAME_VALID <= 1'b0;
      FRAME <= '0;
    end else begin
      FRAME_VALID <= rec_go;
      if (rec_go) FRAME <= '{stamp_r, CYCLE_IN.external, CYCLE_IN.kind,
                             CYCLE_IN.size, CYCLE_IN.addr, CYCLE_IN.data};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TRIG_HIT <= 3'h0;
      EMU_HALT <= 1'b0;
    end else begin
      TRIG_HIT <= running_r ? armed_hit : 3'h0;
      EMU_HALT <= halt_r;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TRACE_REC <= 1'b0;
      SHADOW_EN <= 1'b0;
      HK_ACK <= 1'b0;
    end else begin
      TRACE_REC <= running_r;
      SHADOW_EN <= running_r;
      HK_ACK <= hk_wr;
    end
  end
endmodule : ttu_top
`default_nettype wire

// File: tb/ttu_bus_model.sv
// bus cycle source standing in for the monitored processor
// assumes the bench calls send once per transfer, from one process
`timescale 1ns/10ps
`default_nettype none
module ttu_bus_model (
  input wire logic clk,
  output var ttu_pkg::ttu_cycle_s cyc
);
  import ttu_pkg::*;
  initial cyc = '0;
  task automatic send(input ttu_kind_e k, input logic ext, input logic exe,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    cyc = '{1'b1, exe, ext, k, (k == BUS_WRITE) ? SIZE_BYTE : SIZE_WORD, a, d};
    @(posedge clk);
    #1;
    // released bus shows the inverse, not the last value
    cyc = '{1'b0, 1'b0, 1'b0, BUS_FLUSH, 2'h3, ~a, ~d};
  endtask : send
endmodule : ttu_bus_model
`default_nettype wire

// File: tb/ttu_top_checker.sv
// port-level assertions for the trace and trigger unit
// assumes it is bound to ttu_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module ttu_top_checker #(
  parameter int NQ = ttu_pkg::NUM_QUAL
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire ttu_pkg::ttu_cycle_s CYCLE_IN,
  input wire logic HK_WE,
  input wire logic [5:0] HK_INDEX,
  input wire logic TRACE_ON,
  input wire logic BREAK_ON_TRIG,
  input wire logic [2:0] TRIG_ARM,
  input wire logic EMU_HALT,
  input wire logic TRACE_REC,
  input wire logic SHADOW_EN,
  input wire logic FRAME_VALID,
  input wire ttu_pkg::ttu_frame_s FRAME,
  input wire logic [2:0] TRIG_HIT,
  input wire logic HK_ACK
);
  import ttu_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  sequence took_cycle;
    $past(CYCLE_IN.valid && CYCLE_IN.executed && CYCLE_IN.kind != BUS_FLUSH);
  endsequence
  sequence ack_gap;
    !HK_ACK [*3];
  endsequence
  AST_SHADOW: assert property (SHADOW_EN == TRACE_REC)
    else $error("shadow enable differs from trace state");
  AST_IDLE: assert property (!TRACE_REC |-> !FRAME_VALID && TRIG_HIT == 3'h0)
    else $error("activity while trace is off");
  AST_HALT: assert property (|TRIG_HIT && BREAK_ON_TRIG && $past(BREAK_ON_TRIG) |=> EMU_HALT)
    else $error("no halt after trigger hit");
  AST_HALT_HOLD: assert property (EMU_HALT && TRACE_ON && $past(TRACE_ON)
    && $past(TRACE_ON, 2) |=> EMU_HALT)
    else $error("halt dropped without restart");
  AST_FRAME_EXEC: assert property (FRAME_VALID |-> took_cycle)
    else $error("frame from a non executed cycle");
  AST_FRAME_COPY: assert property (FRAME_VALID |-> FRAME.addr == $past(CYCLE_IN.addr)
    && FRAME.data == $past(CYCLE_IN.data) && FRAME.size == $past(CYCLE_IN.size)
    && FRAME.kind == $past(CYCLE_IN.kind) && FRAME.external == $past(CYCLE_IN.external))
    else $error("frame contents differ from cycle");
  AST_HIT_EXEC: assert property (|TRIG_HIT |-> took_cycle)
    else $error("trigger on a non executed cycle");
  AST_HIT_ARM: assert property ((TRIG_HIT & ~$past(TRIG_ARM)) == 3'h0)
    else $error("unarmed trigger hit");
  AST_ACK: assert property (HK_ACK |-> $past(HK_WE) && $past(HK_INDEX) < NQ ##1 ack_gap)
    else $error("housekeeping ack out of step");
endmodule : ttu_top_checker
`default_nettype wire

// File: tb/ttu_top_tb.sv
// self-checking bench for the trace and trigger unit
// assumes ttu_top, the checker and the bus model are compiled first
`timescale 1ns/10ps
`default_nettype none
module ttu_top_tb;
  import ttu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hk_we = 1'b0, trace_on = 1'b0, brk = 1'b0, win = 1'b0, filt = 1'b0;
  logic stop = 1'b0;
  logic [15:0] cpu_khz = 16'h4e20;
  logic [1:0] hk_unit = 2'h0;
  logic [5:0] hk_index = 6'h00;
  logic [2:0] arm = 3'h7;
  ttu_qual_s hk_qual = '0;
  ttu_cycle_s cyc;
  ttu_frame_s frame;
  logic halt, rec, shadow, fv, ack;
  logic [2:0] hit;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #5 clk = ~clk;
  ttu_bus_model bus (.clk(clk), .cyc(cyc));
  ttu_top uut (.SYS_CLK(clk), .RST(rst), .CYCLE_IN(cyc), .HK_WE(hk_we), .HK_UNIT(hk_unit),
    .HK_INDEX(hk_index), .HK_QUAL(hk_qual), .TRACE_ON(trace_on), .BREAK_ON_TRIG(brk),
    .STOP_TRACE_ON_TRIG(stop), .FILTER_ON(filt), .WINDOW_MODE(win), .TRIG_ARM(arm),
    .CPU_CLK_KHZ(cpu_khz), .EMU_HALT(halt), .TRACE_REC(rec), .SHADOW_EN(shadow),
    .FRAME_VALID(fv), .FRAME(frame), .TRIG_HIT(hit), .HK_ACK(ack));
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic ttu_qual_s q(input logic [1:0] ct, input logic [23:0] a,
      input logic [23:0] am, input logic [15:0] d, input logic [15:0] dm);
    q = '{1'b1, ct, a, a, am, d, d, dm};
  endfunction : q
  task automatic wr(input logic [1:0] u, input logic [5:0] i, input ttu_qual_s qv,
      input logic ok);
    int n;
    n = 0;
    hk_unit = u;
    hk_index = i;
    hk_qual = qv;
    hk_we = 1'b1;
    while (ack !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(ack, ok);
    @(posedge clk);
    #1;
    hk_we = 1'b0;
  endtask : wr
  task automatic restart;
    trace_on = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    trace_on = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : restart
  task automatic trig_case;
    brk = 1'b1;
    restart();
    wr(2'h0, 6'h00, q(CYC_DATA, 24'h005016, 24'hffffff, 16'h0033, 16'h00ff), 1'b1);
    wr(2'h2, 6'h31, q(CYC_DATA, 24'h005000, 24'hffff00, 16'h0033, 16'h00ff), 1'b1);
    wr(2'h1, 6'h32, q(CYC_ALL, 24'h0, 24'h0, 16'h0, 16'h0), 1'b0);
    bus.send(BUS_WRITE, 1'b0, 1'b1, 24'h005016, 16'h1233);
    check({hit, halt}, 4'h0);
    restart();
    bus.send(BUS_FETCH, 1'b0, 1'b1, 24'h005016, 16'h0033);
    check(hit, 3'h0);
    bus.send(BUS_WRITE, 1'b0, 1'b0, 24'h005016, 16'h0033);
    check({hit, fv}, 4'h0);
    bus.send(BUS_WRITE, 1'b0, 1'b1, 24'h005016, 16'h1234);
    check(hit, 3'h0);
    bus.send(BUS_WRITE, 1'b1, 1'b1, 24'h005016, 16'hab33);
    check(hit, 3'h5);
    check({frame.external, frame.size, frame.addr}, {1'b1, SIZE_BYTE, 24'h005016});
    repeat (2) @(posedge clk);
    #1;
    check(halt, 1'b1);
  endtask : trig_case
  task automatic window_case;
    logic [23:0] a[5] = '{24'h50, 24'h100, 24'h50, 24'h200, 24'h50};
    logic [4:0] e = 5'b01110;
    brk = 1'b0;
    win = 1'b1;
    filt = 1'b1;
    wr(2'h0, 6'h00, q(CYC_ALL, 24'h000100, 24'hffffff, 16'h0, 16'h0), 1'b1);
    wr(2'h1, 6'h00, q(CYC_ALL, 24'h000200, 24'hffffff, 16'h0, 16'h0), 1'b1);
    restart();
    for (int i = 0; i < 5; i++) begin
      bus.send(BUS_READ, 1'b0, 1'b1, a[i], 16'h0);
      check(fv, e[i]);
    end
  endtask : window_case
  task automatic off_case;
    trace_on = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({rec, shadow}, 2'b00);
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000100, 16'h0);
    check({fv, hit}, 4'h0);
  endtask : off_case
  task automatic filter_case;
    logic [TS_W-1:0] s0;
    brk = 1'b0;
    win = 1'b0;
    filt = 1'b1;
    cpu_khz = 16'hc350;
    wr(2'h3, 6'h00, q(CYC_FETCH, 24'h000300, 24'hffffff, 16'h0, 16'h0), 1'b1);
    wr(2'h3, 6'h01, q(CYC_NONE, 24'h000300, 24'hffffff, 16'h0, 16'h0), 1'b1);
    wr(2'h3, 6'h02, '{1'b1, CYC_DATA, 24'h000400, 24'h00040f, 24'hffffff,
      16'h0010, 16'h0020, 16'hffff}, 1'b1);
    restart();
    check({rec, shadow}, 2'b11);
    bus.send(BUS_FETCH, 1'b0, 1'b1, 24'h000300, 16'h0);
    check(fv, 1'b1);
    s0 = frame.stamp;
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000300, 16'h0);
    check(fv, 1'b0);
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000408, 16'h0015);
    check(fv, 1'b1);
    check(frame.stamp - s0, 32'h2);
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000410, 16'h0015);
    check(fv, 1'b0);
    bus.send(BUS_WRITE, 1'b0, 1'b1, 24'h000408, 16'h0021);
    check(fv, 1'b0);
  endtask : filter_case
  task automatic stop_case;
    filt = 1'b0;
    brk = 1'b1;
    stop = 1'b1;
    restart();
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000100, 16'h0);
    check({hit, fv}, 4'h3);
    repeat (4) @(posedge clk);
    #1;
    check({rec, halt}, 2'b01);
    bus.send(BUS_READ, 1'b0, 1'b1, 24'h000100, 16'h0);
    check({hit, fv, halt}, 5'h01);
  endtask : stop_case
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    check({halt, rec, shadow, fv, hit, ack}, 8'h00);
    trig_case();
    window_case();
    filter_case();
    stop_case();
    off_case();
    end_sim();
  end
endmodule : ttu_top_tb
bind ttu_top ttu_top_checker #(.NQ(NQ)) chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .CYCLE_IN(CYCLE_IN), .HK_WE(HK_WE), .HK_INDEX(HK_INDEX), .TRACE_ON(TRACE_ON),
  .BREAK_ON_TRIG(BREAK_ON_TRIG), .TRIG_ARM(TRIG_ARM), .EMU_HALT(EMU_HALT),
  .TRACE_REC(TRACE_REC), .SHADOW_EN(SHADOW_EN), .FRAME_VALID(FRAME_VALID),
  .FRAME(FRAME), .TRIG_HIT(TRIG_HIT), .HK_ACK(HK_ACK));
`default_nettype wire
